// ==== expander_pkg.sv ====
package expander_pkg;

  // Width of the parallel input word.
  localparam int unsigned DATA_WIDTH = 12;
  // Falling clock edges that end an access or force input mode.
  localparam int unsigned EDGE_COUNT = 13;
  localparam logic [3:0] EDGE_LAST = 4'hd;
  localparam logic [3:0] CNT_RESET = 4'h0;
  localparam logic [11:0] SHIFT_RESET = 12'h000;
  // System clock and the least pulse width on the link, in ns.
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned PULSE_MIN_NS = 250;
  localparam int unsigned PULSE_CYCLES =
    (PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] PULSE_COUNT = 8'(PULSE_CYCLES);
  localparam logic [7:0] TIMER_RESET = 8'h00;
  // Buffer geometry.
  localparam int unsigned FIFO_WIDTH = 12;
  localparam int unsigned FIFO_DEPTH = 32;

  typedef enum logic [1:0] {
    DEV_INPUT = 2'b00,
    DEV_DRIVE_LOW = 2'b01,
    DEV_SHIFT = 2'b11,
    DEV_UNKNOWN = 2'b10
  } dev_state_type;

  typedef enum logic [2:0] {
    HOST_IDLE = 3'b000,
    HOST_STROBE = 3'b001,
    HOST_CLK_HIGH = 3'b011,
    HOST_CLK_LOW = 3'b010,
    HOST_DONE = 3'b110,
    HOST_FLUSH_HIGH = 3'b111,
    HOST_FLUSH_LOW = 3'b101
  } host_state_type;

endpackage

// ==== expander_if.sv ====
`timescale 1ns/100ps
interface expander_if;
  // Clock line, driven by the host only.
  logic link_clk;
  // Two-way strobe and serial data line, open with pull-up.
  logic host_line_o;
  logic host_line_oe_b;
  logic dev_line_o;
  logic dev_line_oe_b;
  logic strobe_serial_out_line;

  // Pull-up wins when neither side drives; wired-and when both drive.
  assign strobe_serial_out_line =
    (host_line_oe_b | host_line_o) & (dev_line_oe_b | dev_line_o);

  modport device (
    input link_clk,
    input strobe_serial_out_line,
    output dev_line_o,
    output dev_line_oe_b
  );

  modport host (
    output link_clk,
    input strobe_serial_out_line,
    output host_line_o,
    output host_line_oe_b
  );
endinterface

// ==== expander_fifo.sv ====
`timescale 1ns/100ps
module expander_fifo #(
  parameter int unsigned WIDTH = 12,
  parameter int unsigned DEPTH = 32
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Filling side.
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  // Draining side.
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic [AW:0] next_wr_ptr;
  logic [AW:0] next_rd_ptr;
  logic do_wr;
  logic do_rd;

  always_comb begin
    in_ready_o = (wr_ptr - rd_ptr) != (AW + 1)'(DEPTH);
    out_valid_o = wr_ptr != rd_ptr;
    out_data_o = mem[rd_ptr[AW-1:0]];
    do_wr = in_valid_i & in_ready_o;
    do_rd = out_valid_o & out_ready_i;
    next_wr_ptr = wr_ptr + (AW + 1)'(do_wr);
    next_rd_ptr = rd_ptr + (AW + 1)'(do_rd);
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end

  always_ff @(posedge clk_i) begin
    if (do_wr) begin
      mem[wr_ptr[AW-1:0]] <= in_data_i;
    end
  end
endmodule // expander_fifo

// ==== expander_device.sv ====
// Operation
// - Twelve-bit register, parallel load, serial out.
// - Only host clock and one two-way line.
// - Thirteen falling clocks force input mode.
// - Line falling with clock high captures inputs.
// - After capture, drive line low.
// - Each falling clock shifts, input 0 first.
// - Thirteenth falling clock releases the line.
// - Host holds line high between accesses.
// - Host pulses at least 250 ns wide.
// - Host releases line, then flushes with clocks.
// - Turnaround passes through released, pulled-up line; here the device starts driving low during the host strobe.
`timescale 1ns/100ps
module expander_device (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Link.
  expander_if.device link,
  // Parallel inputs, sampled from outside.
  input wire logic [11:0] parallel_inputs_i,
  // Current direction, low while driving.
  output logic line_driven_b_o
);
  localparam logic [11:0] ONE12 = 12'h001;
  localparam logic [3:0] ONE4 = 4'h1;

  logic clk_meta;
  logic clk_sync;
  logic clk_prev;
  logic line_meta;
  logic line_sync;
  logic line_prev;
  logic [11:0] par_meta;
  logic [11:0] par_sync;

  expander_pkg::dev_state_type state;
  expander_pkg::dev_state_type next_state;
  logic [11:0] shift;
  logic [11:0] next_shift;
  logic [3:0] edges;
  logic [3:0] next_edges;
  logic line_o;
  logic next_line_o;
  logic line_oe_b;
  logic next_line_oe_b;
  logic clk_fall;
  logic line_fall;

  // Pins from outside pass two flip-flops before use.
  always_ff @(posedge clk_i) begin
    clk_meta <= link.link_clk;
    clk_sync <= clk_meta;
    clk_prev <= clk_sync;
    line_meta <= link.strobe_serial_out_line;
    line_sync <= line_meta;
    line_prev <= line_sync;
    par_meta <= parallel_inputs_i;
    par_sync <= par_meta;
  end

  always_comb begin
    clk_fall = clk_prev & ~clk_sync;
    line_fall = line_prev & ~line_sync;
    next_state = state;
    next_shift = shift;
    next_edges = edges;
    next_line_o = line_o;
    next_line_oe_b = line_oe_b;
    case (state)
      expander_pkg::DEV_UNKNOWN: begin
        if (clk_fall) begin
          next_edges = edges + ONE4;
          if (edges + ONE4 >= expander_pkg::EDGE_LAST) begin
            next_state = expander_pkg::DEV_INPUT;
            next_edges = expander_pkg::CNT_RESET;
            next_line_oe_b = 1'b1;
          end
        end
      end
      expander_pkg::DEV_INPUT: begin
        if (line_fall && clk_sync) begin
          next_shift = par_sync;
          next_edges = expander_pkg::CNT_RESET;
          next_line_o = 1'b0;
          next_line_oe_b = 1'b0;
          next_state = expander_pkg::DEV_DRIVE_LOW;
        end
      end
      expander_pkg::DEV_DRIVE_LOW, expander_pkg::DEV_SHIFT: begin
        if (clk_fall) begin
          next_edges = edges + ONE4;
          if (edges + ONE4 == expander_pkg::EDGE_LAST) begin
            // Line falls back to the pull-up.
            next_line_oe_b = 1'b1;
            next_line_o = 1'b1;
            next_edges = expander_pkg::CNT_RESET;
            next_state = expander_pkg::DEV_INPUT;
          end else begin
            next_line_o = shift[0];
            next_shift = shift >> ONE12;
            next_state = expander_pkg::DEV_SHIFT;
          end
        end
      end
      default: begin
        next_state = expander_pkg::DEV_UNKNOWN;
      end
    endcase
  end

  // Reset stands for power-up: direction still unknown, line released.
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      state <= expander_pkg::DEV_UNKNOWN;
      shift <= expander_pkg::SHIFT_RESET;
      edges <= expander_pkg::CNT_RESET;
      line_o <= 1'b1;
      line_oe_b <= 1'b1;
    end else begin
      state <= next_state;
      shift <= next_shift;
      edges <= next_edges;
      line_o <= next_line_o;
      line_oe_b <= next_line_oe_b;
    end
  end

  assign link.dev_line_o = line_o;
  assign link.dev_line_oe_b = line_oe_b;
  assign line_driven_b_o = line_oe_b;
endmodule // expander_device

// ==== expander_host.sv ====
`timescale 1ns/100ps
module expander_host (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Link.
  expander_if.host link,
  // Request an access.
  input wire logic start_i,
  output logic busy_o,
  // Received words.
  output logic [11:0] word_o,
  output logic word_valid_o,
  input wire logic word_ready_i
);
  localparam logic [3:0] ONE4 = 4'h1;
  localparam logic [7:0] ONE8 = 8'h01;

  expander_pkg::host_state_type state;
  expander_pkg::host_state_type next_state;
  logic busy;
  logic [7:0] timer;
  logic [7:0] next_timer;
  logic [3:0] edges;
  logic [3:0] next_edges;
  logic [11:0] rx;
  logic [11:0] next_rx;
  logic clk_o;
  logic next_clk_o;
  logic line_o;
  logic next_line_o;
  logic line_oe_b;
  logic next_line_oe_b;
  logic push;
  logic next_push;
  logic fifo_ready;
  logic [11:0] fifo_data;
  logic fifo_valid;
  logic line_meta;
  logic line_sync;
  logic [11:0] out_word;
  logic out_valid;
  logic tick;

  always_ff @(posedge clk_i) begin
    line_meta <= link.strobe_serial_out_line;
    line_sync <= line_meta;
  end

  always_comb begin
    tick = timer == expander_pkg::PULSE_COUNT;
    next_timer = tick ? expander_pkg::TIMER_RESET : timer + ONE8;
    next_state = state;
    next_edges = edges;
    next_rx = rx;
    next_clk_o = clk_o;
    next_line_o = line_o;
    next_line_oe_b = line_oe_b;
    next_push = 1'b0;
    if (tick) begin
      case (state)
        expander_pkg::HOST_FLUSH_HIGH: begin
          next_clk_o = 1'b0;
          next_state = expander_pkg::HOST_FLUSH_LOW;
        end
        expander_pkg::HOST_FLUSH_LOW: begin
          next_clk_o = 1'b1;
          next_edges = edges + ONE4;
          next_state = (edges + ONE4 == expander_pkg::EDGE_LAST)
            ? expander_pkg::HOST_IDLE : expander_pkg::HOST_FLUSH_HIGH;
        end
        expander_pkg::HOST_IDLE: begin
          next_edges = expander_pkg::CNT_RESET;
          // New accesses wait while the buffer is full.
          if (start_i && fifo_ready) begin
            next_line_o = 1'b0;
            next_line_oe_b = 1'b0;
            next_state = expander_pkg::HOST_STROBE;
          end
        end
        expander_pkg::HOST_STROBE: begin
          // Release after a full pulse; the device already drives low by then.
          next_line_o = 1'b1;
          next_line_oe_b = 1'b1;
          next_state = expander_pkg::HOST_CLK_HIGH;
        end
        expander_pkg::HOST_CLK_HIGH: begin
          next_clk_o = 1'b0;
          next_edges = edges + ONE4;
          next_state = expander_pkg::HOST_CLK_LOW;
        end
        expander_pkg::HOST_CLK_LOW: begin
          next_clk_o = 1'b1;
          if (edges == expander_pkg::EDGE_LAST) begin
            next_state = expander_pkg::HOST_DONE;
          end else begin
            next_rx = {line_sync, rx[11:1]};
            next_state = expander_pkg::HOST_CLK_HIGH;
          end
        end
        expander_pkg::HOST_DONE: begin
          next_push = 1'b1;
          next_state = expander_pkg::HOST_IDLE;
        end
        default: begin
          next_state = expander_pkg::HOST_IDLE;
        end
      endcase
    end
  end

  // After reset: release the line first, then flush with clocks.
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      state <= expander_pkg::HOST_FLUSH_HIGH;
      busy <= 1'b1;
      timer <= expander_pkg::TIMER_RESET;
      edges <= expander_pkg::CNT_RESET;
      rx <= expander_pkg::SHIFT_RESET;
      clk_o <= 1'b1;
      line_o <= 1'b1;
      line_oe_b <= 1'b1;
      push <= 1'b0;
    end else begin
      state <= next_state;
      busy <= next_state != expander_pkg::HOST_IDLE;
      timer <= next_timer;
      edges <= next_edges;
      rx <= next_rx;
      clk_o <= next_clk_o;
      line_o <= next_line_o;
      line_oe_b <= next_line_oe_b;
      push <= next_push;
    end
  end

  expander_fifo #(
    .WIDTH(expander_pkg::FIFO_WIDTH),
    .DEPTH(expander_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .in_data_i(rx),
    .in_valid_i(push),
    .in_ready_o(fifo_ready),
    .out_data_o(fifo_data),
    .out_valid_o(fifo_valid),
    .out_ready_i(!out_valid || word_ready_i)
  );

  // Output stage keeps outputs on flip-flops.
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      out_valid <= 1'b0;
      out_word <= expander_pkg::SHIFT_RESET;
    end else if (!out_valid || word_ready_i) begin
      out_valid <= fifo_valid;
      out_word <= fifo_data;
    end
  end

  assign link.link_clk = clk_o;
  assign link.host_line_o = line_o;
  assign link.host_line_oe_b = line_oe_b;
  assign busy_o = busy;
  assign word_o = out_word;
  assign word_valid_o = out_valid;
endmodule // expander_host

// ==== expander_properties.sv ====
`timescale 1ns/100ps
module expander_properties (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Link wires.
  input wire logic link_clk,
  input wire logic host_line_o,
  input wire logic host_line_oe_b,
  input wire logic dev_line_o,
  input wire logic dev_line_oe_b,
  input wire logic strobe_serial_out_line
);
  localparam logic [7:0] MIN_LEN = 8'h32;
  logic prev_clk;
  logic prev_line;
  logic seen;
  logic in_access;
  logic [3:0] edge_cnt;
  logic [7:0] clk_len;
  logic [7:0] str_len;
  logic fall;
  logic host_low;
  logic capture;
  assign fall = prev_clk & ~link_clk;
  assign host_low = ~host_line_oe_b & ~host_line_o;
  assign capture = ~in_access & prev_line & ~strobe_serial_out_line
    & link_clk & dev_line_oe_b;
  // Falls count from reset as well, so the flush uses the same count.
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      prev_clk <= 1'b0;
      prev_line <= 1'b0;
      seen <= 1'b0;
      in_access <= 1'b0;
      edge_cnt <= 4'h0;
      clk_len <= 8'h00;
      str_len <= 8'h00;
    end else begin
      prev_clk <= link_clk;
      prev_line <= strobe_serial_out_line;
      seen <= seen | fall;
      clk_len <= (link_clk != prev_clk) ? 8'h01 :
        clk_len + 8'(clk_len != 8'hff);
      str_len <= host_low ? str_len + 8'(str_len != 8'hff) : 8'h00;
      if (capture) begin
        in_access <= 1'b1;
        edge_cnt <= 4'h0;
      end else if (fall) begin
        in_access <= in_access & (edge_cnt < 4'hc);
        edge_cnt <= edge_cnt + 4'(edge_cnt != 4'hf);
      end
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);

  sequence s_capture;
    capture;
  endsequence
  sequence s_shift_fall;
    fall && in_access && edge_cnt < 4'hc;
  endsequence

  a_drive_needs_strobe: assert property (
    $fell(dev_line_oe_b) |-> !strobe_serial_out_line && link_clk)
    else $error("device drove the line unasked");
  a_low_after_capture: assert property (
    s_capture |-> ##8 (!dev_line_oe_b && !dev_line_o) [*8])
    else $error("no low answer after capture");
  a_drive_in_shift: assert property (
    s_shift_fall |-> ##1 !dev_line_oe_b [*8])
    else $error("line dropped during shift");
  a_bit_held: assert property (
    s_shift_fall |-> ##8 $stable(dev_line_o) [*8])
    else $error("serial bit moved within a phase");
  a_release_thirteen: assert property (
    fall && edge_cnt >= 4'hc |-> ##[1:8] dev_line_oe_b)
    else $error("line kept after thirteen falls");
  a_clk_pulse_wide: assert property (
    seen && link_clk != prev_clk |-> clk_len >= MIN_LEN)
    else $error("link clock phase too short");
  a_strobe_wide: assert property (
    str_len != 8'h00 && !host_low |-> str_len >= MIN_LEN)
    else $error("strobe too short");
  a_strobe_clk_high: assert property (
    host_low |-> link_clk)
    else $error("strobe while link clock low");
  a_host_quiet: assert property (
    in_access && edge_cnt != 4'h0 |-> host_line_oe_b)
    else $error("host drove the line while shifting");
endmodule // expander_properties

// ==== tb.sv ====
`timescale 1ns/100ps
module tb;
  logic clk;
  logic rst_b;
  logic start;
  logic busy;
  logic word_ready;
  logic word_valid;
  logic [11:0] word;
  logic [11:0] pin_word;
  logic line_driven_b;
  logic [31:0] lfsr;
  logic [11:0] exp_q[$];
  logic [11:0] edge_words[4] = '{12'h000, 12'hfff, 12'h001, 12'h800};
  int err_count;
  int num_checks;

  expander_if lk();
  expander_device expander_device_i (.clk_i(clk), .rst_b_i(rst_b),
    .link(lk.device), .parallel_inputs_i(pin_word),
    .line_driven_b_o(line_driven_b));
  expander_host expander_host_i (.clk_i(clk), .rst_b_i(rst_b),
    .link(lk.host), .start_i(start), .busy_o(busy), .word_o(word),
    .word_valid_o(word_valid), .word_ready_i(word_ready));
  expander_properties expander_properties_i (.clk_i(clk),
    .rst_b_i(rst_b), .link_clk(lk.link_clk),
    .host_line_o(lk.host_line_o), .host_line_oe_b(lk.host_line_oe_b),
    .dev_line_o(lk.dev_line_o), .dev_line_oe_b(lk.dev_line_oe_b),
    .strobe_serial_out_line(lk.strobe_serial_out_line));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input string what, input logic [11:0] exp,
    input logic [11:0] got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wait_idle;
    int t;
    step(2);
    for (t = 0; t < 3000 && busy !== 1'b0; t++)
      step(1);
  endtask

  // The start request is a level, so it is dropped once busy shows.
  task automatic access(input logic [11:0] w, output logic taken);
    int t;
    pin_word = w;
    step(4);
    start = 1'b1;
    for (t = 0; t < 120 && busy !== 1'b1; t++)
      step(1);
    start = 1'b0;
    taken = busy;
    if (taken === 1'b1)
      exp_q.push_back(w);
    wait_idle();
  endtask

  task automatic drain(input logic stall);
    int t;
    for (t = 0; t < 4000 && exp_q.size() != 0; t++) begin
      lfsr = lfsr_next(lfsr);
      word_ready = lfsr[0] | ~stall;
      step(1);
    end
    word_ready = 1'b1;
    check("words_left", 12'h000, 12'(exp_q.size()));
  endtask

  always @(posedge clk) begin
    if (rst_b === 1'b1 && word_valid === 1'b1 && word_ready === 1'b1) begin
      check("word_expected", 12'h001, 12'(exp_q.size() != 0));
      if (exp_q.size() != 0)
        check("word", exp_q.pop_front(), word);
    end
  end

  // Bits are read late in each low phase, where the host samples too.
  initial begin : wire_watch
    logic [11:0] w;
    int k;
    forever begin
      @(negedge lk.strobe_serial_out_line iff (lk.link_clk === 1'b1 &&
        rst_b === 1'b1 && lk.dev_line_oe_b === 1'b1));
      w = pin_word;
      step(20);
      check("answer_low", 12'h000,
        12'({lk.dev_line_oe_b, lk.dev_line_o}));
      for (k = 0; k < 13; k++) begin
        @(negedge lk.link_clk);
        step(40);
        check("serial_bit", 12'(k == 12 ? 1'b1 : w[k]),
          12'(lk.strobe_serial_out_line));
      end
    end
  end

  initial begin : watchdog
    #500000;
    err_count++;
    tally_and_finish();
  end

  initial begin : main
    logic ok;
    int i;
    int n;
    rst_b = 1'b0;
    start = 1'b0;
    word_ready = 1'b1;
    pin_word = 12'h000;
    lfsr = 32'h0ca6;
    err_count = 0;
    num_checks = 0;
    // The second pass repeats all but the buffer-fill test after a reset in mid-run.
    for (i = 0; i < 2; i++) begin
      step(12);
      rst_b = 1'b1;
      wait_idle();
      check("line_released", 12'h001, 12'(line_driven_b));
      check("idle_level", 12'h001,
        12'(lk.strobe_serial_out_line));
      foreach (edge_words[j]) begin
        access(edge_words[j], ok);
        check("start_taken", 12'h001, 12'(ok));
      end
      repeat (3) begin
        lfsr = lfsr_next(lfsr);
        access(lfsr[11:0], ok);
      end
      drain(1'b0);
      if (i == 0) begin
        word_ready = 1'b0;
        n = 0;
        ok = 1'b1;
        while (ok === 1'b1 && n < 40) begin
          lfsr = lfsr_next(lfsr);
          access(lfsr[11:0], ok);
          n = n + int'(ok === 1'b1);
        end
        // The output register holds one word beyond the buffer.
        check("fifo_depth", 12'(expander_pkg::FIFO_DEPTH + 1),
          12'(n));
        drain(1'b1);
      end
      rst_b = 1'b0;
    end
    tally_and_finish();
  end
endmodule // tb
